/* File: adc_trig_pkg.sv */
// Constants shared by the trigger delay unit and its converter channels
package adc_trig_pkg;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 16;
   localparam int CODE_W = 5;
   localparam int CTL_W  = 6;
   localparam int CTRL_W = 6;
   localparam int MAXCH  = 4;

   localparam logic [5:0] OFS_CTRL  = 6'h00;
   localparam logic [5:0] OFS_MOD   = 6'h01;
   localparam logic [5:0] OFS_IDLY  = 6'h02;
   localparam logic [5:0] OFS_PRESC = 6'h03;
   localparam logic [5:0] OFS_STAT  = 6'h04;
   localparam logic [5:0] OFS_CSTAT = 6'h05;
   localparam logic [2:0] REG_MISC  = 3'h0;
   localparam logic [2:0] REG_DLY   = 3'h1;
   localparam logic [2:0] REG_CTL   = 3'h2;
   localparam logic [2:0] REG_RES   = 3'h3;

   localparam int CTRL_EN     = 0;
   localparam int CTRL_IRQEN  = 1;
   localparam int CTRL_CONT   = 2;
   localparam int CTRL_SWTRIG = 3;
   localparam int CTRL_SRC_LO = 4;
   localparam logic [1:0] SRC_SW   = 2'h0;
   localparam logic [1:0] SRC_EXT  = 2'h1;
   localparam logic [1:0] SRC_TICK = 2'h2;

   localparam int STAT_DLYIRQ   = 0;
   localparam int STAT_SEQ_ERR_FIRST_FLAG_LO  = 4;
   localparam int STAT_SEQ_ERR_SECOND_FLAG_LO  = 8;
   localparam int CSTAT_DONEA_LO = 0;
   localparam int CSTAT_DONEB_LO = 4;
   localparam int CTL_IE        = 5;

   localparam logic [15:0] MOD_RST   = 16'hFFFF;
   localparam logic [4:0] SEL_REFOUT = 5'h14;
   localparam logic [4:0] SEL_NONE_LO = 5'h16;
   localparam logic [4:0] SEL_NONE_HI = 5'h19;
   localparam logic [4:0] SEL_TEMP   = 5'h1A;
   localparam logic [4:0] SEL_BG     = 5'h1B;

   localparam int CONV_TIME_NS  = 12050;
   localparam int CLK_PERIOD_NS = 40;
   localparam int CONV_CYCLES_DEF =
      (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam logic [1:0] IRQ_NONE   = 2'h0;
   localparam logic [1:0] IRQ_SEQERR = 2'h1;
   localparam logic [1:0] IRQ_DELAY  = 2'h2;
   localparam logic [1:0] IRQ_CONV   = 2'h3;

   typedef enum logic [1:0] {PH_IDLE = 2'b01, PH_RUN = 2'b10} phase_e;
endpackage

/* File: conv_channel.sv */
// One converter: ping-pong control and result sets, single conversion core
`timescale 1ns/1ps
`default_nettype none
module conv_channel
   import adc_trig_pkg::*;
#(
   parameter int CONV_CYCLES = CONV_CYCLES_DEF
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              trigFirst,
   input  wire logic              trigSecond,
   input  wire logic [CTL_W-1:0]  ctlFirst,
   input  wire logic [CTL_W-1:0]  ctlSecond,
   input  wire logic [DATA_W-1:0] sampleIn,
   input  wire logic [DATA_W-1:0] refIn,
   input  wire logic [DATA_W-1:0] tempIn,
   input  wire logic [DATA_W-1:0] bgIn,
   input  wire logic              clrDoneFirst,
   input  wire logic              clrDoneSecond,
   output logic                   busy,
   output logic      [CODE_W-1:0] srcSel,
   output logic      [DATA_W-1:0] resFirst,
   output logic      [DATA_W-1:0] resSecond,
   output logic                   doneFirst,
   output logic                   doneSecond,
   output logic                   irq
);
   localparam int CW = $clog2(CONV_CYCLES + 1);
   if (CONV_CYCLES < 2) begin : g_chk
      $error("CONV_CYCLES must be at least 2");
   end

   phase_e              state_r;
   logic [CW-1:0]       cnt_r;
   logic                setSecond_r;
   logic [CODE_W-1:0]   srcSel_r;
   logic [DATA_W-1:0]   resFirst_r;
   logic [DATA_W-1:0]   resSecond_r;
   logic                doneFirst_r;
   logic                doneSecond_r;
   logic                trigAny;
   logic                lastCyc;
   logic                noneSel;
   logic [DATA_W-1:0]   selValue;

   assign trigAny = trigFirst | trigSecond;
   assign lastCyc = (state_r == PH_RUN) && (cnt_r == CW'(CONV_CYCLES - 1));
   assign noneSel = (srcSel_r >= SEL_NONE_LO) && (srcSel_r <= SEL_NONE_HI);
   // Internal sources override the pin sample
   assign selValue = (srcSel_r == SEL_REFOUT) ? refIn :
                     (srcSel_r == SEL_TEMP)   ? tempIn :
                     (srcSel_r == SEL_BG)     ? bgIn :
                     noneSel                  ? '0 : sampleIn;

   // One core: a new pre-trigger abandons the running conversion
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r <= PH_IDLE;
         cnt_r <= '0;
         setSecond_r <= 1'b0;
         srcSel_r <= '0;
      end else if (trigAny) begin
         state_r <= PH_RUN;
         cnt_r <= '0;
         setSecond_r <= ~trigFirst;
         srcSel_r <= trigFirst ? ctlFirst[CODE_W-1:0]
                               : ctlSecond[CODE_W-1:0];
      end else if (lastCyc) begin
         state_r <= PH_IDLE;
      end else if (state_r == PH_RUN) begin
         cnt_r <= cnt_r + CW'(1);
      end
   end

   // Results land in the set of the launching pre-trigger
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         resFirst_r <= '0;
         resSecond_r <= '0;
      end else if (lastCyc && !setSecond_r) begin
         resFirst_r <= selValue;
      end else if (lastCyc) begin
         resSecond_r <= selValue;
      end
   end

   // Completion beats a clear in the same cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         doneFirst_r <= 1'b0;
         doneSecond_r <= 1'b0;
      end else begin
         doneFirst_r <= (lastCyc && !setSecond_r) ||
                        (doneFirst_r && !clrDoneFirst);
         doneSecond_r <= (lastCyc && setSecond_r) ||
                         (doneSecond_r && !clrDoneSecond);
      end
   end

   assign busy = (state_r == PH_RUN);
   assign srcSel = srcSel_r;
   assign resFirst = resFirst_r;
   assign resSecond = resSecond_r;
   assign doneFirst = doneFirst_r;
   assign doneSecond = doneSecond_r;
   assign irq = (doneFirst_r && ctlFirst[CTL_IE]) ||
                (doneSecond_r && ctlSecond[CTL_IE]);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   result_set_a: assert property (
      lastCyc && !setSecond_r && !trigAny |=>
         resFirst_r == $past(selValue) && doneFirst_r)
      else $error("first result not stored");
   done_second_a: assert property (
      lastCyc && setSecond_r && !trigAny |=>
         doneSecond_r && !busy ##0 irq == (ctlSecond[CTL_IE] ||
         (doneFirst_r && ctlFirst[CTL_IE])))
      else $error("second completion not flagged");
   src_mux_a: assert property (
      lastCyc && setSecond_r && !trigAny && srcSel_r == SEL_TEMP |=>
         resSecond_r == $past(tempIn))
      else $error("temperature code not selected");
endmodule
`default_nettype wire

/* File: trigger_delay_unit.sv */
// Programmable trigger delay unit scheduling one to four converter channels (CH_N)
`timescale 1ns/1ps
`default_nettype none
module trigger_delay_unit
   import adc_trig_pkg::*;
#(
   parameter int CH_N        = 4,
   parameter int CONV_CYCLES = CONV_CYCLES_DEF
) (
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic [ADDR_W-1:0]      addr,
   input  wire logic [DATA_W-1:0]      wrData,
   input  wire logic                   wrEn,
   input  wire logic                   rdEn,
   output logic      [DATA_W-1:0]      rdData,
   input  wire logic                   extTrig,
   input  wire logic                   intervalTick,
   input  wire logic [CH_N*DATA_W-1:0] sampleIn,
   input  wire logic [DATA_W-1:0]      refIn,
   input  wire logic [DATA_W-1:0]      tempIn,
   input  wire logic [DATA_W-1:0]      bgIn,
   output logic      [CH_N-1:0]        hwTrigSelFirst,
   output logic      [CH_N-1:0]        hwTrigSelSecond,
   output logic      [CH_N*CODE_W-1:0] srcSel,
   output logic                        delayIrq,
   output logic                        seqErrIrq,
   output logic                        convIrq,
   output logic      [1:0]             irqSource
);
   if (CH_N < 1 || CH_N > MAXCH) begin : g_chk
      $error("CH_N must be 1 to 4");
   end

   phase_e              state_r;
   logic [CTRL_W-1:0]   ctrl_r;
   logic [DATA_W-1:0]   mod_r;
   logic [DATA_W-1:0]   idly_r;
   logic [DATA_W-1:0]   presc_r;
   logic [DATA_W-1:0]   cnt_r;
   logic [DATA_W-1:0]   prCnt_r;
   logic [DATA_W-1:0]   dlyFirst_r  [CH_N];
   logic [DATA_W-1:0]   dlySecond_r [CH_N];
   logic [CTL_W-1:0]    ctlFirst_r  [CH_N];
   logic [CTL_W-1:0]    ctlSecond_r [CH_N];
   logic [CH_N-1:0]     trigFirst_r;
   logic [CH_N-1:0]     trigSecond_r;
   logic [CH_N-1:0]     errFirst_r;
   logic [CH_N-1:0]     errSecond_r;
   logic                dlyFlag_r;
   logic                ext1_r;
   logic                ext2_r;
   logic                ext3_r;
   logic                extLvl_r;
   logic [DATA_W-1:0]   rdData_r;

   logic [DATA_W-1:0]   resFirst  [CH_N];
   logic [DATA_W-1:0]   resSecond [CH_N];
   logic [CH_N-1:0]     convBusy;
   logic [CH_N-1:0]     doneFirst;
   logic [CH_N-1:0]     doneSecond;
   logic [CH_N-1:0]     convIrqVec;
   logic [CH_N-1:0]     doneClrFirst;
   logic [CH_N-1:0]     doneClrSecond;
   logic [CH_N-1:0]     errClrFirst;
   logic [CH_N-1:0]     errClrSecond;
   logic [CH_N-1:0]     busyHitFirst;

   logic                en;
   logic                irqEn;
   logic                contMode;
   logic [1:0]          srcMode;
   logic                swPulse;
   logic                extStable;
   logic                extRise;
   logic                startSrc;
   logic                startReq;
   logic                tickEn;
   logic                tickRun;
   logic                atMod;
   logic                dlySet;
   logic                statWr;
   logic                cstatWr;
   logic [2:0]          region;
   logic [1:0]          chIdx;
   logic                slotSecond;
   logic                chOk;
   logic [DATA_W-1:0]   statWord;
   logic [DATA_W-1:0]   cstatWord;
   logic [DATA_W-1:0]   miscRd;
   logic [DATA_W-1:0]   chanRd;
   logic [DATA_W-1:0]   rdValue;

   function automatic logic hitAt(input logic run,
                                  input logic [DATA_W-1:0] count,
                                  input logic [DATA_W-1:0] value);
      return run && (count == value);
   endfunction

   assign en = ctrl_r[CTRL_EN];
   assign irqEn = ctrl_r[CTRL_IRQEN];
   assign contMode = ctrl_r[CTRL_CONT];
   assign srcMode = ctrl_r[CTRL_SRC_LO +: 2];
   assign swPulse = wrEn && (addr == OFS_CTRL) && wrData[CTRL_SWTRIG];

   // Pin input: act only once stages two and three agree
   assign extStable = (ext2_r == ext3_r);
   assign extRise = extStable && ext3_r && !extLvl_r;

   // Start sources
   assign startSrc = (srcMode == SRC_SW)   ? swPulse :
                     (srcMode == SRC_EXT)  ? extRise :
                     (srcMode == SRC_TICK) ? intervalTick : 1'b0;
   assign startReq = en && (state_r == PH_IDLE) && startSrc;

   // Prescaler divides by presc_r + 1, so zero counts every cycle
   assign tickEn = (prCnt_r == presc_r);
   assign tickRun = tickEn && (state_r == PH_RUN);
   // Last count is modulus minus one, so a cycle lasts modulus ticks
   assign atMod = (cnt_r == mod_r - DATA_W'(1));
   assign busyHitFirst = trigFirst_r & convBusy;
   assign dlySet = irqEn && hitAt(tickRun, cnt_r, idly_r);

   assign region = addr[5:3];
   assign chIdx = addr[2:1];
   assign slotSecond = addr[0];
   assign chOk = (int'(chIdx) < CH_N);
   assign statWr = wrEn && (addr == OFS_STAT);
   assign cstatWr = wrEn && (addr == OFS_CSTAT);
   assign errClrFirst = statWr ? wrData[STAT_SEQ_ERR_FIRST_FLAG_LO +: CH_N] : '0;
   assign errClrSecond = statWr ? wrData[STAT_SEQ_ERR_SECOND_FLAG_LO +: CH_N] : '0;
   assign doneClrFirst = cstatWr ? wrData[CSTAT_DONEA_LO +: CH_N] : '0;
   assign doneClrSecond = cstatWr ? wrData[CSTAT_DONEB_LO +: CH_N] : '0;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ext1_r <= 1'b0;
         ext2_r <= 1'b0;
         ext3_r <= 1'b0;
         extLvl_r <= 1'b0;
      end else begin
         ext1_r <= extTrig;
         ext2_r <= ext1_r;
         ext3_r <= ext2_r;
         extLvl_r <= extStable ? ext3_r : extLvl_r;
      end
   end

   // Configuration writes; unmapped offsets are ignored
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_r <= '0;
         mod_r <= MOD_RST;
         idly_r <= '0;
         presc_r <= '0;
         for (int i = 0; i < CH_N; i++) begin
            dlyFirst_r[i] <= '0;
            dlySecond_r[i] <= '0;
            ctlFirst_r[i] <= '0;
            ctlSecond_r[i] <= '0;
         end
      end else if (wrEn) begin
         if (addr == OFS_CTRL) begin
            ctrl_r <= wrData[CTRL_W-1:0] & ~CTRL_W'(1 << CTRL_SWTRIG);
         end
         if (addr == OFS_MOD) begin
            mod_r <= wrData;
         end
         if (addr == OFS_IDLY) begin
            idly_r <= wrData;
         end
         if (addr == OFS_PRESC) begin
            presc_r <= wrData;
         end
         if (region == REG_DLY && chOk && !slotSecond) begin
            dlyFirst_r[chIdx] <= wrData;
         end
         if (region == REG_DLY && chOk && slotSecond) begin
            dlySecond_r[chIdx] <= wrData;
         end
         if (region == REG_CTL && chOk && !slotSecond) begin
            ctlFirst_r[chIdx] <= wrData[CTL_W-1:0];
         end
         if (region == REG_CTL && chOk && slotSecond) begin
            ctlSecond_r[chIdx] <= wrData[CTL_W-1:0];
         end
      end
   end

   // Counter: restart from zero, wrap at modulus
   always_ff @(posedge clk) begin
      if (!rst_n || !en) begin
         state_r <= PH_IDLE;
         cnt_r <= '0;
         prCnt_r <= '0;
      end else if (startReq) begin
         state_r <= PH_RUN;
         cnt_r <= '0;
         prCnt_r <= '0;
      end else if (state_r == PH_RUN) begin
         prCnt_r <= tickEn ? '0 : prCnt_r + DATA_W'(1);
         if (tickEn && atMod) begin
            cnt_r <= '0;
            state_r <= contMode ? PH_RUN : PH_IDLE;
         end else if (tickEn) begin
            cnt_r <= cnt_r + DATA_W'(1);
         end
      end
   end

   // Pre-trigger pulses, one per compare match
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         trigFirst_r <= '0;
         trigSecond_r <= '0;
      end else begin
         for (int i = 0; i < CH_N; i++) begin
            trigFirst_r[i] <= hitAt(tickRun, cnt_r, dlyFirst_r[i]);
            trigSecond_r[i] <= hitAt(tickRun, cnt_r, dlySecond_r[i]);
         end
      end
   end

   // Sticky flags; a new event beats a clear in the same cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         errFirst_r <= '0;
         errSecond_r <= '0;
         dlyFlag_r <= 1'b0;
      end else begin
         errFirst_r <= busyHitFirst |
                       (errFirst_r & ~errClrFirst);
         errSecond_r <= (trigSecond_r & convBusy) |
                        (errSecond_r & ~errClrSecond);
         dlyFlag_r <= dlySet ||
                      (dlyFlag_r && !(statWr && wrData[STAT_DLYIRQ]));
      end
   end

   for (genvar g = 0; g < CH_N; g++) begin : g_conv
      conv_channel #(
         .CONV_CYCLES (CONV_CYCLES)
      ) u_conv (
         .clk           (clk),
         .rst_n         (rst_n),
         .trigFirst     (trigFirst_r[g]),
         .trigSecond    (trigSecond_r[g]),
         .ctlFirst      (ctlFirst_r[g]),
         .ctlSecond     (ctlSecond_r[g]),
         .sampleIn      (sampleIn[g*DATA_W +: DATA_W]),
         .refIn         (refIn),
         .tempIn        (tempIn),
         .bgIn          (bgIn),
         .clrDoneFirst  (doneClrFirst[g]),
         .clrDoneSecond (doneClrSecond[g]),
         .busy          (convBusy[g]),
         .srcSel        (srcSel[g*CODE_W +: CODE_W]),
         .resFirst      (resFirst[g]),
         .resSecond     (resSecond[g]),
         .doneFirst     (doneFirst[g]),
         .doneSecond    (doneSecond[g]),
         .irq           (convIrqVec[g])
      );
   end

   // Read path
   assign statWord = {4'h0, MAXCH'(errSecond_r), MAXCH'(errFirst_r),
                      3'h0, dlyFlag_r};
   assign cstatWord = {8'h00, MAXCH'(doneSecond), MAXCH'(doneFirst)};
   assign miscRd = (addr == OFS_CTRL)  ? DATA_W'(ctrl_r) :
                   (addr == OFS_MOD)   ? mod_r :
                   (addr == OFS_IDLY)  ? idly_r :
                   (addr == OFS_PRESC) ? presc_r :
                   (addr == OFS_STAT)  ? statWord :
                   (addr == OFS_CSTAT) ? cstatWord : '0;
   assign chanRd =
      !chOk                                 ? '0 :
      (region == REG_DLY && !slotSecond)    ? dlyFirst_r[chIdx] :
      (region == REG_DLY)                   ? dlySecond_r[chIdx] :
      (region == REG_CTL && !slotSecond)    ? DATA_W'(ctlFirst_r[chIdx]) :
      (region == REG_CTL)                   ? DATA_W'(ctlSecond_r[chIdx]) :
      (region == REG_RES && !slotSecond)    ? resFirst[chIdx] :
      (region == REG_RES)                   ? resSecond[chIdx] : '0;
   assign rdValue = (region == REG_MISC) ? miscRd : chanRd;

   // Data shows only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdData_r <= '0;
      end else begin
         rdData_r <= rdEn ? rdValue : '0;
      end
   end

   assign rdData = rdData_r;
   assign hwTrigSelFirst = trigFirst_r;
   assign hwTrigSelSecond = trigSecond_r;
   assign delayIrq = dlyFlag_r;
   // No enable in the path: errors always reach the pin
   assign seqErrIrq = |{errFirst_r, errSecond_r};
   assign convIrq = |convIrqVec;
   // Sequence errors first, then the delay interrupt
   assign irqSource = seqErrIrq ? IRQ_SEQERR :
                      delayIrq  ? IRQ_DELAY :
                      convIrq   ? IRQ_CONV : IRQ_NONE;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   trig_first_a: assert property (
      tickRun && en && cnt_r == dlyFirst_r[0] |=>
         hwTrigSelFirst[0] ##1 !hwTrigSelFirst[0] || tickRun)
      else $error("first pre-trigger missing");
   trig_second_a: assert property (
      hwTrigSelSecond[0] |-> $past(cnt_r) == $past(dlySecond_r[0]) &&
         $past(tickRun))
      else $error("second pre-trigger at wrong count");
   delay_irq_a: assert property (
      dlySet |=> delayIrq && irqSource != IRQ_CONV)
      else $error("delay interrupt not raised");
   seq_err_a: assert property (
      busyHitFirst != '0 |=>
         (errFirst_r & $past(busyHitFirst)) == $past(busyHitFirst) &&
         seqErrIrq && irqSource == IRQ_SEQERR)
      else $error("sequence error not flagged");
   seq_err_hold_a: assert property (
      seqErrIrq && !statWr |=> seqErrIrq)
      else $error("sequence error dropped without clear");
   irq_prio_a: assert property (
      delayIrq && convIrq && !seqErrIrq |-> irqSource == IRQ_DELAY)
      else $error("delay interrupt lost priority");
   mod_wrap_a: assert property (
      tickRun && atMod && !contMode |=>
         cnt_r == '0 && state_r == PH_IDLE)
      else $error("single cycle did not stop at modulus");
   cont_mode_a: assert property (
      tickRun && atMod && contMode && en |=>
         cnt_r == '0 && state_r == PH_RUN)
      else $error("continuous cycle did not restart");
   hold_count_a: assert property (
      state_r == PH_RUN && !tickEn && en |=> $stable(cnt_r))
      else $error("counter moved between prescaler ticks");
   start_a: assert property (
      startReq |=> state_r == PH_RUN && cnt_r == '0 && prCnt_r == '0)
      else $error("start request not taken");
endmodule
`default_nettype wire

/* File: analog_front.sv */
// Analog sources and start pin that feed the converters
`timescale 1ns/1ps
`default_nettype none
module analog_front
   import adc_trig_pkg::*;
#(
   parameter int CH_N = 4
) (
   input  wire logic                   clk,
   input  wire logic                   fireExt,
   output logic                        extTrig,
   output logic      [CH_N*DATA_W-1:0] sampleIn,
   output logic      [DATA_W-1:0]      refIn,
   output logic      [DATA_W-1:0]      tempIn,
   output logic      [DATA_W-1:0]      bgIn
);
   logic [1:0] hold = 2'h0;
   // Pin stays up a few cycles so the three-stage synchroniser sees it
   always_ff @(posedge clk) begin
      hold <= fireExt ? 2'h3 : (hold == 2'h0 ? 2'h0 : hold - 2'h1);
   end
   assign extTrig = fireExt | (hold != 2'h0);
   // Distinct value per converter exposes crossed channels
   for (genvar g = 0; g < CH_N; g++) begin : g_pin
      assign sampleIn[g*DATA_W+:DATA_W] = DATA_W'(16'h1111 * (g + 1));
   end
   assign refIn  = 16'hA5A0;
   assign tempIn = 16'h7E70;
   assign bgIn   = 16'h0B60;
endmodule
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the trigger delay unit
`timescale 1ns/1ps
`default_nettype none
module tb;
   import adc_trig_pkg::*;
   logic                clk, rst_n, wrEn, rdEn, intervalTick, fireExt;
   logic                extTrig, delayIrq, seqErrIrq, convIrq;
   logic [ADDR_W-1:0]   addr;
   logic [DATA_W-1:0]   wrData, rdData, refIn, tempIn, bgIn;
   logic [4*DATA_W-1:0] sampleIn;
   logic [3:0]          hwTrigSelFirst, hwTrigSelSecond;
   logic [4*CODE_W-1:0] srcSel;
   logic [1:0]          irqSource;
   int                  failures, check_count, cyc, tStart, tIrq, nFirst0;
   int                  tPrev0;
   int                  tFirst [4];
   int                  tSecond [4];
   analog_front #(.CH_N(4)) front (.clk(clk), .fireExt(fireExt),
      .extTrig(extTrig), .sampleIn(sampleIn), .refIn(refIn),
      .tempIn(tempIn), .bgIn(bgIn));
   // Short conversion keeps the run small
   trigger_delay_unit #(.CH_N(4), .CONV_CYCLES(4)) dut (.clk(clk),
      .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrEn(wrEn),
      .rdEn(rdEn), .rdData(rdData), .extTrig(extTrig),
      .intervalTick(intervalTick), .sampleIn(sampleIn), .refIn(refIn),
      .tempIn(tempIn), .bgIn(bgIn), .hwTrigSelFirst(hwTrigSelFirst),
      .hwTrigSelSecond(hwTrigSelSecond), .srcSel(srcSel),
      .delayIrq(delayIrq), .seqErrIrq(seqErrIrq), .convIrq(convIrq),
      .irqSource(irqSource));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc > 3000) begin
         failures++;
         test_done();
      end
      if (hwTrigSelFirst[0] === 1'b1) begin
         tPrev0 = tFirst[0];
         nFirst0++;
      end
      for (int g = 0; g < 4; g++) begin
         if (hwTrigSelFirst[g] === 1'b1) tFirst[g] = cyc;
         if (hwTrigSelSecond[g] === 1'b1) tSecond[g] = cyc;
      end
      if (delayIrq === 1'b1 && tIrq < 0) tIrq = cyc;
   end
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chkT(input string n, input int e, input int g);
      check_count++;
      if (g != e) begin
         failures++;
         $display("ERROR %s expected %0d seen %0d", n, e, g);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      addr <= a;
      wrData <= d;
      wrEn <= 1'b1;
      @(posedge clk);
      tStart = cyc;
      wrEn <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdChk(input logic [5:0] a, input logic [15:0] e);
      addr <= a;
      rdEn <= 1'b1;
      @(posedge clk);
      rdEn <= 1'b0;
      @(posedge clk);
      chk("rdData", e, rdData);
   endtask
   task automatic t_sched;
      logic [4:0] cB [4];
      logic [15:0] eB [4];
      cB = '{SEL_REFOUT, SEL_TEMP, SEL_BG, SEL_NONE_LO};
      eB = '{refIn, tempIn, bgIn, 16'h0000};
      for (int g = 0; g < 4; g++) begin
         wr(6'(8 + 2*g), 16'(2 + 3*g));
         wr(6'(9 + 2*g), 16'(20 + 5*g));
         wr(6'(16 + 2*g), 16'h0005);
         wr(6'(17 + 2*g), 16'(cB[g]) | (g == 1 ? 16'h0020 : 16'h0000));
      end
      wr(OFS_MOD, 16'h0050);
      wr(OFS_IDLY, 16'h0032);
      // Enable first: a start written beside the enable is not taken
      wr(OFS_CTRL, 16'h0003);
      tIrq = -1;
      nFirst0 = 0;
      wr(OFS_CTRL, 16'h000B);
      repeat (200) @(posedge clk);
      for (int g = 0; g < 4; g++) begin
         chkT("firstTime", tStart + 4 + 3*g, tFirst[g]);
         chkT("secondTime", tStart + 22 + 5*g, tSecond[g]);
         rdChk(6'(24 + 2*g), sampleIn[g*16+:16]);
         rdChk(6'(25 + 2*g), eB[g]);
         chk("srcSel", 16'(cB[g]), 16'(srcSel[g*CODE_W+:CODE_W]));
      end
      chkT("irqTime", tStart + 52, tIrq);
      chkT("firstCount", 1, nFirst0);
      rdChk(OFS_CSTAT, 16'h00FF);
      chk("convIrq", 16'h0001, {15'h0, convIrq});
      chk("irqSource", 16'(IRQ_DELAY), {14'h0, irqSource});
      wr(OFS_STAT, 16'hFFFF);
      wr(OFS_CSTAT, 16'hFFFF);
      rdChk(OFS_STAT, 16'h0000);
      chk("convIrq", 16'h0000, {15'h0, convIrq});
      $display("test sched done");
   endtask
   task automatic t_seqerr;
      // Second of ch0 and first of ch1 land on a busy core
      wr(6'h08, 16'h0002);
      wr(6'h09, 16'h0003);
      wr(6'h0A, 16'h0005);
      wr(6'h0B, 16'h0003);
      wr(OFS_CTRL, 16'h0009);
      repeat (120) @(posedge clk);
      rdChk(OFS_STAT, 16'h0120);
      chk("delayIrq", 16'h0000, {15'h0, delayIrq});
      chk("seqErrIrq", 16'h0001, {15'h0, seqErrIrq});
      chk("irqSource", 16'(IRQ_SEQERR), {14'h0, irqSource});
      wr(OFS_STAT, 16'hFFFF);
      rdChk(OFS_STAT, 16'h0000);
      chk("seqErrIrq", 16'h0000, {15'h0, seqErrIrq});
      $display("test seqerr done");
   endtask
   task automatic t_modes;
      wr(OFS_PRESC, 16'h0001);
      wr(OFS_MOD, 16'h001E);
      wr(OFS_CTRL, 16'h0015);
      nFirst0 = 0;
      fireExt <= 1'b1;
      @(posedge clk);
      fireExt <= 1'b0;
      repeat (300) @(posedge clk);
      chkT("period", 60, tFirst[0] - tPrev0);
      chkT("repeats", 1, int'(nFirst0 >= 4));
      wr(OFS_CTRL, 16'h0000);
      repeat (3) @(posedge clk);
      nFirst0 = 0;
      repeat (100) @(posedge clk);
      chkT("firstCount", 0, nFirst0);
      wr(OFS_CTRL, 16'h0021);
      intervalTick <= 1'b1;
      @(posedge clk);
      intervalTick <= 1'b0;
      repeat (200) @(posedge clk);
      chkT("firstCount", 1, nFirst0);
      rdChk(6'h3F, 16'h0000);
      $display("test modes done");
   endtask
   task automatic test_done;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      {rst_n, wrEn, rdEn, intervalTick, fireExt} = 5'h00;
      addr = 6'h00;
      wrData = 16'h0000;
      {failures, check_count, cyc, nFirst0, tPrev0} = '0;
      tIrq = -1;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      rdChk(OFS_MOD, 16'hFFFF);
      rdChk(OFS_STAT, 16'h0000);
      t_sched();
      t_seqerr();
      t_modes();
      test_done();
   end
endmodule
`default_nettype wire
